// ===== src/gpio_port_pkg.sv
// Shared constants, field layouts and carriers for the GPIO port block
package gpio_port_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_DIR           = 6'h00;
  localparam logic [5:0] IDX_DIR_SET       = 6'h01;
  localparam logic [5:0] IDX_DIR_CLR       = 6'h02;
  localparam logic [5:0] IDX_DIR_TGL       = 6'h03;
  localparam logic [5:0] IDX_OUT           = 6'h04;
  localparam logic [5:0] IDX_OUT_SET       = 6'h05;
  localparam logic [5:0] IDX_OUT_CLR       = 6'h06;
  localparam logic [5:0] IDX_OUT_TGL       = 6'h07;
  localparam logic [5:0] IDX_IN            = 6'h08;
  localparam logic [5:0] IDX_INT_FLAGS     = 6'h09;
  localparam logic [5:0] IDX_PORT_CONTROL  = 6'h0A;
  localparam logic [5:0] IDX_PIN_CTRL_BASE = 6'h10;

  // Field positions
  localparam int unsigned PORT_CTRL_SLEW_BIT = 0;
  localparam int unsigned ADDR_IDX_LSB       = 2;

  // Reset values
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic [7:0] OUT_RST       = 8'h00;
  localparam logic [7:0] PIN_CTRL_RST  = 8'h00;
  localparam logic [7:0] PORT_CTRL_RST = 8'h00;

  // Interrupt dead time of partially asynchronous pins, in clock cycles
  localparam logic [1:0] DEAD_CYCLES = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Sense configuration encodings
  typedef enum logic [2:0] {
    SENSE_INT_OFF   = 3'h0,
    SENSE_BOTH      = 3'h1,
    SENSE_RISING    = 3'h2,
    SENSE_FALLING   = 3'h3,
    SENSE_INPUT_OFF = 3'h4,
    SENSE_LOW_LEVEL = 3'h5
  } sense_t;

  // Per-pin control byte: invert at bit 7, pull-up at bit 3, sense at bits 2:0
  typedef struct packed {
    logic       invert_enable;
    logic [2:0] spare;
    logic       pullup_enable;
    logic [2:0] sense_configuration;
  } pin_ctrl_t;

  // One register write from the bus front end
  typedef struct packed {
    logic [5:0] index;
    logic [7:0] data;
    logic       lane0;
  } reg_write_t;

endpackage

// ===== src/gpio_sync2.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module gpio_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ===== src/gpio_axil_slave.sv
// AXI4-Lite front end turning bus beats into byte register accesses
`timescale 1ns/1ps
`default_nettype none
module gpio_axil_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output var  logic              o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output var  logic              o_wready,
  output var  logic [1:0]        o_bresp,
  output var  logic              o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output var  logic              o_arready,
  output var  logic [31:0]       o_rdata,
  output var  logic [1:0]        o_rresp,
  output var  logic              o_rvalid,
  input  wire logic              i_rready,
  output var  logic              o_wr_valid,
  output var  gpio_port_pkg::reg_write_t o_wr,
  input  wire logic              i_wr_ok,
  output var  logic [5:0]        o_rd_index,
  input  wire logic [7:0]        i_rd_data,
  input  wire logic              i_rd_ok
);

  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;

  // Address and data may arrive in either order; each is held until both are in
  assign o_awready  = !aw_held_r && !o_bvalid;
  assign o_wready   = !w_held_r && !o_bvalid;
  assign o_wr_valid = aw_held_r && w_held_r && !o_bvalid;
  assign o_wr       = '{index: awaddr_r[gpio_port_pkg::ADDR_IDX_LSB +: 6],
                        data: wbyte_r, lane0: wlane_r};
  assign o_arready  = !o_rvalid;
  assign o_rd_index = i_araddr[gpio_port_pkg::ADDR_IDX_LSB +: 6];

  // Write channel capture and response
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= gpio_port_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wbyte_r  <= i_wdata[7:0];
        wlane_r  <= i_wstrb[0];
      end
      if (o_wr_valid) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= i_wr_ok ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_DECERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read data is registered on the same edge that takes the address
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= gpio_port_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {24'h00_0000, i_rd_data};
      o_rresp  <= i_rd_ok ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_DECERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== src/gpio_port_pin_control.sv
// GPIO port: direction, output, input, per-pin control, sensing and events
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control #(
  parameter int unsigned     NUM_PINS           = 8,
  parameter logic [NUM_PINS-1:0] PARTIAL_ASYNC_MASK = '0
) (
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  // AXI4-Lite register slave
  input  wire logic [7:0]          s_axil_awaddr,
  input  wire logic                s_axil_awvalid,
  output var  logic                s_axil_awready,
  input  wire logic [31:0]         s_axil_wdata,
  input  wire logic [3:0]          s_axil_wstrb,
  input  wire logic                s_axil_wvalid,
  output var  logic                s_axil_wready,
  output var  logic [1:0]          s_axil_bresp,
  output var  logic                s_axil_bvalid,
  input  wire logic                s_axil_bready,
  input  wire logic [7:0]          s_axil_araddr,
  input  wire logic                s_axil_arvalid,
  output var  logic                s_axil_arready,
  output var  logic [31:0]         s_axil_rdata,
  output var  logic [1:0]          s_axil_rresp,
  output var  logic                s_axil_rvalid,
  input  wire logic                s_axil_rready,
  // Pin side
  input  wire logic [NUM_PINS-1:0] i_pin_level,
  output var  logic [NUM_PINS-1:0] o_pin_drive,
  output var  logic [NUM_PINS-1:0] o_pin_oe,
  output var  logic [NUM_PINS-1:0] o_pullup_en,
  output var  logic [NUM_PINS-1:0] o_input_buffer_en,
  output var  logic                o_slew_limit,
  output var  logic [NUM_PINS-1:0] o_pin_event,
  output var  logic                o_irq,
  output var  logic                o_wake
);

  // Bus front end signals
  logic                      wr_valid;
  gpio_port_pkg::reg_write_t wr;
  logic                      wr_ok;
  logic [5:0]                rd_index;
  logic [7:0]                rd_data;
  logic                      rd_ok;
  logic                      wr_hit;
  logic [NUM_PINS-1:0]       wr_bits;

  // Register state
  logic [NUM_PINS-1:0]       dir_r;
  logic [NUM_PINS-1:0]       out_r;
  logic [NUM_PINS-1:0]       in_r;
  logic [NUM_PINS-1:0]       prev_r;
  logic [NUM_PINS-1:0]       flags_r;
  logic [NUM_PINS-1:0]       flags_nxt;
  logic                      slew_r;
  gpio_port_pkg::pin_ctrl_t  pin_ctrl_r [NUM_PINS];
  logic [1:0]                dead_r;

  // Per-pin derived signals
  logic [NUM_PINS-1:0]       sync_level;
  logic [NUM_PINS-1:0]       invert;
  logic [NUM_PINS-1:0]       buf_on;
  logic [NUM_PINS-1:0]       int_on;
  logic [NUM_PINS-1:0]       hit;
  logic [NUM_PINS-1:0]       hit_ok;
  logic [NUM_PINS-1:0]       wake_hit;

  // Register index is backed by a register
  function automatic logic addr_mapped(input logic [5:0] idx);
    logic pin_reg;
    pin_reg = (idx >= gpio_port_pkg::IDX_PIN_CTRL_BASE) &&
              (idx < gpio_port_pkg::IDX_PIN_CTRL_BASE + 6'(NUM_PINS));
    return pin_reg || (idx <= gpio_port_pkg::IDX_PORT_CONTROL);
  endfunction

  // Sense condition from current and previous internal level
  function automatic logic sense_hit(input logic [2:0] sense, input logic cur,
                                     input logic prev);
    logic res;
    res = 1'b0;
    case (sense)
      gpio_port_pkg::SENSE_BOTH:      res = cur ^ prev;
      gpio_port_pkg::SENSE_RISING:    res = cur & ~prev;
      gpio_port_pkg::SENSE_FALLING:   res = ~cur & prev;
      gpio_port_pkg::SENSE_LOW_LEVEL: res = ~cur;
      default:                        res = 1'b0;
    endcase
    return res;
  endfunction

  gpio_axil_slave #(
    .ADDR_W (8)
  ) u_bus (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_awaddr   (s_axil_awaddr),
    .i_awvalid  (s_axil_awvalid),
    .o_awready  (s_axil_awready),
    .i_wdata    (s_axil_wdata),
    .i_wstrb    (s_axil_wstrb),
    .i_wvalid   (s_axil_wvalid),
    .o_wready   (s_axil_wready),
    .o_bresp    (s_axil_bresp),
    .o_bvalid   (s_axil_bvalid),
    .i_bready   (s_axil_bready),
    .i_araddr   (s_axil_araddr),
    .i_arvalid  (s_axil_arvalid),
    .o_arready  (s_axil_arready),
    .o_rdata    (s_axil_rdata),
    .o_rresp    (s_axil_rresp),
    .o_rvalid   (s_axil_rvalid),
    .i_rready   (s_axil_rready),
    .o_wr_valid (wr_valid),
    .o_wr       (wr),
    .i_wr_ok    (wr_ok),
    .o_rd_index (rd_index),
    .i_rd_data  (rd_data),
    .i_rd_ok    (rd_ok)
  );

  // Pins are resynchronised before any clocked logic looks at them
  gpio_sync2 #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_pin_level),
    .o_sync  (sync_level)
  );

  // A write with lane 0 off is accepted but changes nothing
  assign wr_ok   = addr_mapped(wr.index);
  assign wr_hit  = wr_valid && wr.lane0;
  assign wr_bits = wr.data[NUM_PINS-1:0];

  // Per-pin decode of the control bytes
  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      invert[n] = pin_ctrl_r[n].invert_enable;
      buf_on[n] = pin_ctrl_r[n].sense_configuration != gpio_port_pkg::SENSE_INPUT_OFF;
      int_on[n] = buf_on[n] &&
                  pin_ctrl_r[n].sense_configuration != gpio_port_pkg::SENSE_INT_OFF;
    end
  end

  // Direction register and its set, clear and toggle aliases
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dir_r <= gpio_port_pkg::DIR_RST[NUM_PINS-1:0];
    end else if (wr_hit) begin
      case (wr.index)
        gpio_port_pkg::IDX_DIR:     dir_r <= wr_bits;
        gpio_port_pkg::IDX_DIR_SET: dir_r <= dir_r | wr_bits;
        gpio_port_pkg::IDX_DIR_CLR: dir_r <= dir_r & ~wr_bits;
        gpio_port_pkg::IDX_DIR_TGL: dir_r <= dir_r ^ wr_bits;
        default:                    dir_r <= dir_r;
      endcase
    end
  end

  // Output value register; a write of ones to the input register toggles too
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_r <= gpio_port_pkg::OUT_RST[NUM_PINS-1:0];
    end else if (wr_hit) begin
      case (wr.index)
        gpio_port_pkg::IDX_OUT:     out_r <= wr_bits;
        gpio_port_pkg::IDX_OUT_SET: out_r <= out_r | wr_bits;
        gpio_port_pkg::IDX_OUT_CLR: out_r <= out_r & ~wr_bits;
        gpio_port_pkg::IDX_OUT_TGL: out_r <= out_r ^ wr_bits;
        gpio_port_pkg::IDX_IN:      out_r <= out_r ^ wr_bits;
        default:                    out_r <= out_r;
      endcase
    end
  end

  // Port control: slew limit shared by the whole port
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      slew_r <= gpio_port_pkg::PORT_CTRL_RST[gpio_port_pkg::PORT_CTRL_SLEW_BIT];
    end else if (wr_hit && wr.index == gpio_port_pkg::IDX_PORT_CONTROL) begin
      slew_r <= wr.data[gpio_port_pkg::PORT_CTRL_SLEW_BIT];
    end
  end

  // Per-pin control bytes at base index plus pin number
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int n = 0; n < NUM_PINS; n++) begin
        pin_ctrl_r[n] <= gpio_port_pkg::pin_ctrl_t'(gpio_port_pkg::PIN_CTRL_RST);
      end
    end else begin
      for (int n = 0; n < NUM_PINS; n++) begin
        if (wr_hit && wr.index == gpio_port_pkg::IDX_PIN_CTRL_BASE + 6'(n)) begin
          pin_ctrl_r[n] <= gpio_port_pkg::pin_ctrl_t'(wr.data);
        end
      end
    end
  end

  // Input value: synchronised level in the selected sense, frozen while the
  // buffer is off; flipping invert moves this level and so counts as an edge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      in_r   <= '0;
      prev_r <= '0;
    end else begin
      for (int n = 0; n < NUM_PINS; n++) begin
        if (buf_on[n]) begin
          in_r[n] <= sync_level[n] ^ invert[n];
        end else begin
          in_r[n] <= in_r[n];
        end
      end
      prev_r <= in_r;
    end
  end

  // Sense detection on the clocked path
  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      hit[n] = int_on[n] &&
               sense_hit(pin_ctrl_r[n].sense_configuration, in_r[n], prev_r[n]);
    end
  end

  // Partially asynchronous pins sit out the dead time after any raised flag
  assign hit_ok = hit & ~(PARTIAL_ASYNC_MASK & {NUM_PINS{dead_r != 2'h0}});

  // Flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    if (wr_hit && wr.index == gpio_port_pkg::IDX_INT_FLAGS) begin
      flags_nxt = flags_nxt & ~wr_bits;
    end
    flags_nxt = flags_nxt | hit_ok;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Dead-time counter restarts whenever a flag is raised
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dead_r <= 2'h0;
    end else if (|hit_ok) begin
      dead_r <= gpio_port_pkg::DEAD_CYCLES;
    end else if (dead_r != 2'h0) begin
      dead_r <= dead_r - 2'h1;
    end
  end

  // Request stays up while any enabled pin keeps its flag
  assign o_irq = |(flags_r & int_on);

  // Clockless wake path: raw level against the last captured level, so a
  // change is seen even while the clock is stopped. Partially asynchronous
  // pins only wake from both-edge or low-level sensing.
  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      wake_hit[n] = int_on[n] &&
                    sense_hit(pin_ctrl_r[n].sense_configuration,
                              i_pin_level[n] ^ invert[n], in_r[n]);
      if (PARTIAL_ASYNC_MASK[n] &&
          pin_ctrl_r[n].sense_configuration != gpio_port_pkg::SENSE_BOTH &&
          pin_ctrl_r[n].sense_configuration != gpio_port_pkg::SENSE_LOW_LEVEL) begin
        wake_hit[n] = 1'b0;
      end
    end
  end

  assign o_wake = |wake_hit;

  // Pin drive; reset values make drivers off and buffers on with no clock
  assign o_pin_oe          = dir_r;
  assign o_pin_drive       = out_r ^ invert;
  assign o_input_buffer_en = buf_on;
  assign o_slew_limit      = slew_r;

  // A process, not an assign, so it also wakes on the control bytes the
  // function reads
  always_comb begin
    o_pullup_en = pullup_bits() & ~dir_r;
  end

  // Events follow the pin asynchronously and read zero with the buffer off
  assign o_pin_event = (i_pin_level ^ invert) & buf_on;

  function automatic logic [NUM_PINS-1:0] pullup_bits();
    logic [NUM_PINS-1:0] res;
    res = '0;
    for (int n = 0; n < NUM_PINS; n++) begin
      res[n] = pin_ctrl_r[n].pullup_enable;
    end
    return res;
  endfunction

  // Read mux; aliases read back the register they act on
  always_comb begin
    rd_data = 8'h00;
    rd_ok   = addr_mapped(rd_index);
    case (rd_index)
      gpio_port_pkg::IDX_DIR,
      gpio_port_pkg::IDX_DIR_SET,
      gpio_port_pkg::IDX_DIR_CLR,
      gpio_port_pkg::IDX_DIR_TGL:      rd_data = 8'(dir_r);
      gpio_port_pkg::IDX_OUT,
      gpio_port_pkg::IDX_OUT_SET,
      gpio_port_pkg::IDX_OUT_CLR,
      gpio_port_pkg::IDX_OUT_TGL:      rd_data = 8'(out_r);
      gpio_port_pkg::IDX_IN:           rd_data = 8'(in_r);
      gpio_port_pkg::IDX_INT_FLAGS:    rd_data = 8'(flags_r);
      gpio_port_pkg::IDX_PORT_CONTROL: rd_data = 8'(slew_r);
      default: begin
        for (int n = 0; n < NUM_PINS; n++) begin
          if (rd_index == gpio_port_pkg::IDX_PIN_CTRL_BASE + 6'(n)) begin
            rd_data = pin_ctrl_r[n];
          end
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== tb/gpio_port_pin_control_monitor.sv
// Concurrent checks on the GPIO port pins and its register bus
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control_monitor #(
  parameter int unsigned NUM_PINS = 8
) (
  input wire logic                i_clock,
  input wire logic                i_rst,
  input wire logic [7:0]          s_axil_awaddr,
  input wire logic                s_axil_awvalid,
  input wire logic                s_axil_awready,
  input wire logic [31:0]         s_axil_wdata,
  input wire logic [3:0]          s_axil_wstrb,
  input wire logic                s_axil_wvalid,
  input wire logic                s_axil_wready,
  input wire logic                s_axil_bvalid,
  input wire logic                s_axil_arvalid,
  input wire logic                s_axil_arready,
  input wire logic                s_axil_rvalid,
  input wire logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic [NUM_PINS-1:0] o_pullup_en,
  input wire logic [NUM_PINS-1:0] o_input_buffer_en,
  input wire logic [NUM_PINS-1:0] o_pin_event,
  input wire logic                o_slew_limit
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Both write channels taken together with lane 0 live
  sequence wr_taken;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready && s_axil_wstrb[0];
  endsequence
  // Response comes on the second edge, not the first
  sequence resp_late;
    !s_axil_bvalid ##1 s_axil_bvalid;
  endsequence
  a_write_resp: assert property (wr_taken |=> resp_late)
    else $error("write response timing wrong");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read accepted while answer pending");
  a_reset_state: assert property ($fell(i_rst) |-> o_pin_oe == '0 && o_input_buffer_en == '1)
    else $error("drivers or buffers wrong after reset");
  a_dir_set: assert property (wr_taken ##0 s_axil_awaddr == 8'h04 |->
    ##2 o_pin_oe == ($past(o_pin_oe, 2) | $past(s_axil_wdata[NUM_PINS-1:0], 2)))
    else $error("direction set alias wrong");
  a_dir_toggle: assert property (wr_taken ##0 s_axil_awaddr == 8'h0C |->
    ##2 o_pin_oe == ($past(o_pin_oe, 2) ^ $past(s_axil_wdata[NUM_PINS-1:0], 2)))
    else $error("direction toggle alias wrong");
  a_slew_write: assert property (wr_taken ##0 s_axil_awaddr == 8'h28 |->
    ##2 o_slew_limit == $past(s_axil_wdata[0], 2))
    else $error("slew limit not written");
  a_pullup_gate: assert property ((o_pin_oe & o_pullup_en) == '0)
    else $error("pull-up on while driving");
  a_event_gate: assert property ((o_pin_event & ~o_input_buffer_en) == '0)
    else $error("event seen with buffer off");
endmodule
bind gpio_port_pin_control gpio_port_pin_control_monitor #(.NUM_PINS(NUM_PINS))
  gpio_port_pin_control_monitor_i (.*);
`default_nettype wire

// ===== tb/gpio_pin_partner.sv
// Outside circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_partner (
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_drive,
  input  wire logic [7:0] i_ext,
  output var  logic [7:0] o_level
);
  // Port driver wins over the outside source; outside always drives
  assign o_level = (i_oe & i_drive) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// ===== tb/gpio_port_pin_control_test.sv
// Self-checking bench for the GPIO port: bus tasks and scripted scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module gpio_port_pin_control_test;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00, ext = 8'hFF, pin;
  logic [31:0] wdata   = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, slew, wake;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  oe, drv, pu, bufen, evt, rd_v;
  logic [3:0]  fall    = 4'b1101;
  logic [7:0]  modes [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
  logic [7:0]  wa [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0]  wd [9] = '{8'h0F, 8'h30, 8'h05, 8'hFF, 8'h00, 8'h81, 8'h01, 8'h03, 8'h80};
  logic [7:0]  we [9] = '{8'h0F, 8'h3F, 8'h3A, 8'hC5, 8'h00, 8'h81, 8'h80, 8'h83, 8'h03};
  int          num_errors = 0;
  int          n_tests    = 0;

  // Pin 0 is partially asynchronous, so the dead time can be seen
  gpio_port_pin_control #(.PARTIAL_ASYNC_MASK(8'h01)) gpio_port_pin_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .i_pin_level(pin), .o_pin_drive(drv), .o_pin_oe(oe), .o_pullup_en(pu),
    .o_input_buffer_en(bufen), .o_slew_limit(slew), .o_pin_event(evt), .o_irq(irq),
    .o_wake(wake));
  gpio_pin_partner gpio_pin_partner_i (.i_oe(oe), .i_drive(drv), .i_ext(ext), .o_level(pin));

  // Clock, 8 ns period
  initial begin
    forever #4 i_clock = ~i_clock;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Ready is sampled mid-cycle so a release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge i_clock);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge i_clock);
      ta   = awvalid & awready;
      tw   = wvalid & wready;
      resp = bresp;
      @(posedge i_clock);
      if (bvalid) begin
        bready <= 1'b0;
        return;
      end
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    num_errors++;
    test_done();
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta;
    @(posedge i_clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge i_clock);
      ta   = arvalid & arready;
      rd_v = rdata[7:0];
      resp = rresp;
      @(posedge i_clock);
      if (rvalid) begin
        rready <= 1'b0;
        return;
      end
      if (ta) arvalid <= 1'b0;
    end
    num_errors++;
    test_done();
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, rd_v)
  endtask

  // Ends at a falling edge so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    wt(1);
    `CHK("oe", 8'h00, oe)
    `CHK("bufen", 8'hFF, bufen)
    rc(8'h00, 8'h00);
    // Each of the four edge and level sense modes sees a fall then a rise on pin 0
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, modes[i]);
      wt(6);
      wr(8'h24, 8'hFF);
      ext <= 8'hFE;
      wt(8);
      `CHK("irq", fall[i], irq)
      `CHK("wake", (i == 3), wake)
      rc(8'h24, {7'h00, fall[i]});
      wr(8'h24, 8'h00);
      rc(8'h24, {7'h00, fall[i]});
      ext <= 8'hFF;
      wt(8);
      rc(8'h24, 8'h01);
      wr(8'h24, 8'h01);
      rc(8'h24, 8'h00);
    end
    // A pin 1 flag holds off pin 0 one cycle later; later pin 0 edges count
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h01);
    wt(6);
    wr(8'h24, 8'hFF);
    ext <= 8'hFD;
    @(posedge i_clock);
    ext <= 8'hFC;
    wt(8);
    rc(8'h24, 8'h02);
    ext <= 8'hFD;
    wt(8);
    rc(8'h24, 8'h03);
    wr(8'h40, 8'h00);
    ext <= 8'hA5;
    wt(5);
    rc(8'h20, 8'hA5);
    wr(8'h48, 8'h80);
    rc(8'h48, 8'h80);
    wt(5);
    rc(8'h20, 8'hA1);
    `CHK("evt", 8'hA1, evt)
    wr(8'h4C, 8'h04);
    wt(1);
    `CHK("bufen", 8'hF7, bufen)
    @(posedge i_clock);
    ext <= 8'h5A;
    wt(5);
    rc(8'h20, 8'h56);
    `CHK("evt", 8'h56, evt)
    wr(8'h44, 8'h08);
    wt(1);
    `CHK("pu", 8'h02, pu)
    // Direction and output aliases, each followed by a read-back
    for (int i = 0; i < 9; i++) begin
      wr(wa[i], wd[i]);
      rc(wa[i] < 8'h10 ? 8'h00 : 8'h10, we[i]);
    end
    wr(8'h04, 8'h02);
    wt(1);
    `CHK("oe", 8'hC7, oe)
    `CHK("drv", 8'h07, drv)
    `CHK("pu", 8'h00, pu)
    wt(4);
    rc(8'h20, 8'h13);
    wr(8'h28, 8'h01);
    wt(1);
    `CHK("slew", 1'b1, slew)
    rc(8'h2C, 8'h00);
    `CHK("rresp", gpio_port_pkg::RESP_DECERR, resp)
    wr(8'h2C, 8'h55);
    `CHK("bresp", gpio_port_pkg::RESP_DECERR, resp)
    test_done();
  end
endmodule
`default_nettype wire
